// *** bench/ibus_host_chk.sv ***
/* checker for the bus host: handshake order, address extension, grant
   masking and start of vector service. bound onto ibus_host below. */
`timescale 1ns/1ns
module ibus_host_chk
   import ibus_host_pkg::*;
(
   // clock and reset
   input wire logic             MCLK,
   input wire logic             RST_B,
   // transfer side
   input wire logic [17:0]      ADDR_O,
   input wire logic             ADDR_OE,
   input wire logic [1:0]       XTYPE_O,
   input wire logic             DATA_OE,
   input wire logic             MASTER_SYNC_O,
   input wire logic             SLAVE_SYNC_I,
   input wire logic             CMD_DONE,
   // arbitration side
   input wire logic             DMA_GRANT_O,
   input wire logic [LVL_N-1:0] LEVEL_GRANT_O,
   input wire logic [15:0]      PSW_OUT,
   input wire logic             VEC_TAKEN
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_B);
   logic [2:0] glvl;
   // level number of the line being granted, 0 when none
   always_comb begin
      glvl = 3'h0;
      for (int i = 0; i < LVL_N; i++)
         if (LEVEL_GRANT_O[i]) glvl = 3'(i + LVL_BASE);
   end
   property p_setup;
      $rose(MASTER_SYNC_O) |-> $past(ADDR_OE) && $stable(ADDR_O) && $stable(XTYPE_O);
   endproperty
   a_setup: assert property (p_setup) else $error("sync before address settled");
   property p_hold;
      MASTER_SYNC_O && $past(MASTER_SYNC_O) |-> ADDR_OE && $stable(ADDR_O) && $stable(XTYPE_O);
   endproperty
   a_hold: assert property (p_hold) else $error("address moved under sync");
   property p_drop;
      $rose(SLAVE_SYNC_I) && MASTER_SYNC_O |-> ##[1:5] !MASTER_SYNC_O;
   endproperty
   a_drop: assert property (p_drop) else $error("sync kept after slave answer");
   property p_wait;
      $rose(MASTER_SYNC_O) |-> !SLAVE_SYNC_I;
   endproperty
   a_wait: assert property (p_wait) else $error("new sync while slave busy");
   property p_done;
      $rose(CMD_DONE) |-> !SLAVE_SYNC_I && !MASTER_SYNC_O && !ADDR_OE;
   endproperty
   a_done: assert property (p_done) else $error("done before handshake closed");
   property p_dir;
      MASTER_SYNC_O |-> DATA_OE == XTYPE_O[1];
   endproperty
   a_dir: assert property (p_dir) else $error("data drive wrong for type");
   property p_ext;
      ADDR_OE |-> ADDR_O[17:16] == (ADDR_O[15:13] == BANK_ALL1 ? EXT_ONES : 2'h0);
   endproperty
   a_ext: assert property (p_ext) else $error("bad extension bits");
   property p_mask;
      |LEVEL_GRANT_O |-> $onehot(LEVEL_GRANT_O) && PSW_OUT[7:5] < glvl;
   endproperty
   a_mask: assert property (p_mask) else $error("grant at masked level");
   property p_dma;
      DMA_GRANT_O |-> LEVEL_GRANT_O == '0;
   endproperty
   a_dma: assert property (p_dma) else $error("level grant beside dma grant");
   property p_vec;
      $rose(VEC_TAKEN) |-> ##[1:30] $rose(MASTER_SYNC_O) && XTYPE_O == XT_WRWORD;
   endproperty
   a_vec: assert property (p_vec) else $error("no push after vector");
   c_pause: cover property ($rose(MASTER_SYNC_O) && XTYPE_O == XT_RDPAUSE);
   c_lvl: cover property ($rose(|LEVEL_GRANT_O));
   c_dma: cover property ($rose(DMA_GRANT_O));
   c_vec: cover property ($rose(VEC_TAKEN));
endmodule : ibus_host_chk
bind ibus_host ibus_host_chk i_chk (
   .MCLK(MCLK), .RST_B(RST_B), .ADDR_O(ADDR_O), .ADDR_OE(ADDR_OE), .XTYPE_O(XTYPE_O),
   .DATA_OE(DATA_OE), .MASTER_SYNC_O(MASTER_SYNC_O), .SLAVE_SYNC_I(SLAVE_SYNC_I),
   .CMD_DONE(CMD_DONE), .DMA_GRANT_O(DMA_GRANT_O), .LEVEL_GRANT_O(LEVEL_GRANT_O),
   .PSW_OUT(PSW_OUT), .VEC_TAKEN(VEC_TAKEN));

// *** bench/ibus_mem.sv ***
/* word store standing for the device: interlocked slave handshake,
   byte lanes, read-pause flag. the bench resolves the wired data bus. */
`timescale 1ns/1ns
module ibus_mem
   import ibus_host_pkg::*;
(
   // clock
   input  wire logic        mclk,
   // bus as seen by the slave
   input  wire logic [17:0] addr,
   input  wire logic [1:0]  xtype,
   input  wire logic        msync,
   input  wire logic [15:0] din,
   input  wire logic [3:0]  lat,
   output logic [15:0]      dout,
   output logic             ssync
);
   logic [15:0] mem_ff [256];
   logic [15:0] rd_ff    = '0;
   logic [3:0]  cnt_ff   = '0;
   logic        oe_ff    = 1'b0;
   logic        ss_ff    = 1'b0;
   logic        pause_ff = 1'b0;
   wire  [7:0]  wa       = addr[8:1]; // no decode, every address lands
   wire         wr_lo    = xtype == XT_WRWORD || xtype == XT_WRBYTE && !addr[0];
   wire         wr_hi    = xtype == XT_WRWORD || xtype == XT_WRBYTE && addr[0];
   // released lines show the inverse, so a stale word cannot pass
   assign dout  = oe_ff ? rd_ff : ~rd_ff;
   assign ssync = ss_ff;
   // one slave cycle per master_sync, answer on the lat+1-th clock it is seen high
   always_ff @(posedge mclk) begin
      if (!msync) begin
         ss_ff  <= 1'b0;
         oe_ff  <= 1'b0;
         cnt_ff <= 4'h0;
      end else if (!ss_ff) begin
         cnt_ff <= cnt_ff + 4'h1;
         if (!xtype[1]) begin
            rd_ff <= mem_ff[wa];
            oe_ff <= 1'b1;
         end
         if (cnt_ff == lat) begin
            ss_ff    <= 1'b1;
            pause_ff <= xtype == XT_RDPAUSE; // pause flag recorded on read_pause, never read by this model
            if (wr_lo) mem_ff[wa][7:0] <= din[7:0];
            if (wr_hi) mem_ff[wa][15:8] <= din[15:8];
         end
      end
   end
endmodule : ibus_mem

// *** bench/tb_ibus_host.sv ***
/* self-checking bench for the bus host: transfers of all four types,
   dma and level arbitration, vector service. memory model on the bus. */
`timescale 1ns/1ns
module tb_ibus_host
   import ibus_host_pkg::*;
;
   logic MCLK = 1'b0, RST_B = 1'b0, CE = 1'b1, CMD_GO = 1'b0, INSN_END = 1'b0;
   logic TRAP_SEEN = 1'b0, PSW_WR = 1'b0, DMA_REQUEST_I = 1'b0, SELECT_ACK_I = 1'b0;
   logic VECTOR_INTERRUPT_I = 1'b0, dev_bb = 1'b0, vec_oe = 1'b0;
   logic [15:0] CMD_ADDR = '0, CMD_WDATA = '0, PSW_IN = '0, VEC_DATA_I = '0, vec_d = '0;
   logic [1:0] CMD_TYPE = '0, XTYPE_O, last_t;
   logic [LVL_N-1:0] LEVEL_REQUEST_I = '0, LEVEL_GRANT_O;
   logic [3:0] lat = 4'h1;
   logic CMD_BUSY, CMD_DONE, VEC_TAKEN, ADDR_OE, DATA_OE, MASTER_SYNC_O, DMA_GRANT_O;
   logic BUS_BUSY_O, SLAVE_SYNC_I, BUS_BUSY_I;
   logic [15:0] CMD_RDATA, PSW_OUT, PC_OUT, DATA_O, DATA_I, s_d;
   logic [17:0] ADDR_O, last_a;
   int n_mismatch = 0, checks = 0, n_vec = 0;
   // wired bus: host, vector source, then the slave model
   assign BUS_BUSY_I = BUS_BUSY_O | dev_bb;
   assign DATA_I = DATA_OE ? DATA_O : vec_oe ? vec_d : s_d;
   initial begin
      forever #5 MCLK = ~MCLK;
   end
   ibus_host i_dut (
      .MCLK(MCLK), .RST_B(RST_B), .CE(CE), .CMD_ADDR(CMD_ADDR), .CMD_TYPE(CMD_TYPE),
      .CMD_WDATA(CMD_WDATA), .CMD_GO(CMD_GO), .INSN_END(INSN_END), .TRAP_SEEN(TRAP_SEEN),
      .PSW_IN(PSW_IN), .PSW_WR(PSW_WR), .CMD_BUSY(CMD_BUSY), .CMD_DONE(CMD_DONE),
      .CMD_RDATA(CMD_RDATA), .PSW_OUT(PSW_OUT), .PC_OUT(PC_OUT), .VEC_TAKEN(VEC_TAKEN),
      .ADDR_O(ADDR_O), .ADDR_OE(ADDR_OE), .XTYPE_O(XTYPE_O), .DATA_O(DATA_O),
      .DATA_OE(DATA_OE), .DATA_I(DATA_I), .MASTER_SYNC_O(MASTER_SYNC_O),
      .SLAVE_SYNC_I(SLAVE_SYNC_I), .DMA_REQUEST_I(DMA_REQUEST_I), .DMA_GRANT_O(DMA_GRANT_O),
      .LEVEL_REQUEST_I(LEVEL_REQUEST_I), .LEVEL_GRANT_O(LEVEL_GRANT_O),
      .SELECT_ACK_I(SELECT_ACK_I), .BUS_BUSY_I(BUS_BUSY_I), .BUS_BUSY_O(BUS_BUSY_O),
      .VECTOR_INTERRUPT_I(VECTOR_INTERRUPT_I), .VEC_DATA_I(VEC_DATA_I));
   ibus_mem i_mem (.mclk(MCLK), .addr(ADDR_O), .xtype(XTYPE_O), .msync(MASTER_SYNC_O),
      .din(DATA_I), .lat(lat), .dout(s_d), .ssync(SLAVE_SYNC_I));
   // what the host put on the lines when it raised sync
   always @(posedge MASTER_SYNC_O) begin
      last_a = ADDR_O;
      last_t = XTYPE_O;
   end
   // vector service starts, counted once per pulse away from the launching edge
   always @(negedge MCLK) if (VEC_TAKEN === 1'b1) n_vec++;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_sim;
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_sim
   task automatic hang;
      n_mismatch++;
      end_sim;
   endtask : hang
   task automatic tick(input int n);
      repeat (n) @(negedge MCLK);
   endtask : tick
   // one command, go strobed for one clock, then wait for the done pulse
   task automatic xfer(input logic [15:0] a, input logic [1:0] t, input logic [15:0] d);
      int n;
      @(posedge MCLK);
      CMD_ADDR <= a;
      CMD_TYPE <= t;
      CMD_WDATA <= d;
      CMD_GO <= 1'b1;
      @(posedge MCLK);
      CMD_GO <= 1'b0;
      @(negedge MCLK);
      chk(32'({CMD_BUSY, BUS_BUSY_O}), 32'h3);
      for (n = 0; n < 300 && CMD_DONE !== 1'b1; n++) @(negedge MCLK);
      if (n == 300) hang;
      chk(32'({CMD_BUSY, BUS_BUSY_O}), 32'h0);
   endtask : xfer
   task automatic wg(input logic [4:0] e);
      int n;
      for (n = 0; n < 50 && {DMA_GRANT_O, LEVEL_GRANT_O} !== e; n++) @(negedge MCLK);
      chk(32'({DMA_GRANT_O, LEVEL_GRANT_O}), 32'(e));
   endtask : wg
   task automatic insn(input logic trap);
      @(posedge MCLK);
      TRAP_SEEN <= trap;
      @(posedge MCLK);
      TRAP_SEEN <= 1'b0;
      INSN_END <= 1'b1;
      @(posedge MCLK);
      INSN_END <= 1'b0;
      tick(10);
   endtask : insn
   task automatic t_rw;
      xfer(16'h0020, XT_WRWORD, 16'h1234);
      chk(32'(last_t), 32'(XT_WRWORD));
      xfer(16'h0021, XT_WRBYTE, 16'hAB00);
      xfer(16'h0020, XT_RDWORD, 16'h0000);
      chk(32'(CMD_RDATA), 32'h0000AB34);
      lat <= 4'h5;
      xfer(16'h0020, XT_RDPAUSE, 16'h0000);
      chk(32'(CMD_RDATA), 32'h0000AB34);
      chk(32'(last_t), 32'(XT_RDPAUSE));
      xfer(16'h0020, XT_WRBYTE, 16'h00CD);
      xfer(16'h0020, XT_RDWORD, 16'h0000);
      chk(32'(CMD_RDATA), 32'h0000ABCD);
      xfer(16'hE004, XT_WRWORD, 16'h5A5A);
      chk(32'(last_a), 32'h0003E004);
      xfer(16'hE004, XT_RDWORD, 16'h0000);
      chk(32'(CMD_RDATA), 32'h00005A5A);
      $display("test rw done");
   endtask : t_rw
   task automatic t_dma;
      @(posedge MCLK);
      DMA_REQUEST_I <= 1'b1;
      wg(5'h10);
      @(posedge MCLK);
      SELECT_ACK_I <= 1'b1;
      DMA_REQUEST_I <= 1'b0;
      wg(5'h00);
      @(posedge MCLK);
      dev_bb <= 1'b1;
      VECTOR_INTERRUPT_I <= 1'b1;
      tick(10);
      chk(32'(BUS_BUSY_O), 32'h0);
      chk(32'(n_vec), 32'h0);
      @(posedge MCLK);
      dev_bb <= 1'b0; // passive release
      SELECT_ACK_I <= 1'b0;
      VECTOR_INTERRUPT_I <= 1'b0;
      tick(6); // release crosses two flops before the host is idle again
      xfer(16'h0020, XT_RDWORD, 16'h0000);
      chk(32'(CMD_RDATA), 32'h0000ABCD);
      $display("test dma done");
   endtask : t_dma
   task automatic t_lvl;
      int n;
      xfer(16'h0030, XT_WRWORD, 16'h4321);
      xfer(16'h0032, XT_WRWORD, 16'h00E0);
      @(posedge MCLK);
      PSW_IN <= 16'h0080;
      PSW_WR <= 1'b1;
      @(posedge MCLK);
      PSW_WR <= 1'b0;
      LEVEL_REQUEST_I <= 4'h1;
      insn(1'b0);
      chk(32'(LEVEL_GRANT_O), 32'h0);
      @(posedge MCLK);
      LEVEL_REQUEST_I <= 4'h3;
      insn(1'b1);
      chk(32'(LEVEL_GRANT_O), 32'h0);
      insn(1'b0);
      wg(5'h02);
      @(posedge MCLK);
      SELECT_ACK_I <= 1'b1;
      LEVEL_REQUEST_I <= 4'h1;
      wg(5'h00);
      @(posedge MCLK);
      dev_bb <= 1'b1;
      VECTOR_INTERRUPT_I <= 1'b1;
      vec_oe <= 1'b1;
      vec_d <= 16'h0030;
      tick(4);
      @(posedge MCLK);
      dev_bb <= 1'b0;
      SELECT_ACK_I <= 1'b0;
      for (n = 0; n < 50 && VEC_TAKEN !== 1'b1; n++) @(negedge MCLK);
      if (n == 50) hang;
      @(posedge MCLK);
      VECTOR_INTERRUPT_I <= 1'b0;
      vec_oe <= 1'b0;
      LEVEL_REQUEST_I <= 4'h0;
      for (n = 0; n < 300 && CMD_DONE !== 1'b1; n++) @(negedge MCLK);
      if (n == 300) hang;
      chk(32'(n_vec), 32'h1);
      chk(32'(PC_OUT), 32'h00004321);
      chk(32'(PSW_OUT), 32'h000000E0);
      xfer(16'h01FE, XT_RDWORD, 16'h0000);
      chk(32'(CMD_RDATA), 32'h00000080);
      xfer(16'h01FC, XT_RDWORD, 16'h0000);
      chk(32'(CMD_RDATA), 32'h00000000);
      $display("test level done");
   endtask : t_lvl
   initial begin
      repeat (6) @(posedge MCLK);
      RST_B <= 1'b1;
      t_rw;
      t_dma;
      t_lvl;
      end_sim;
   end
endmodule : tb_ibus_host

// *** core/ibus_host.sv ***
/*
 * processor-side bus host: issues word/byte transfers with the
 * interlocked master_sync/slave_sync handshake, arbitrates dma_request ahead
 * of level requests and levels against the status-word priority, drives grants, watches
 * bus_busy hand-over and takes vector_interrupt, then pushes status and pc
 * and loads a new pair from the vector.
 * assumes bus pins are asynchronous and open-drain; the bench resolves the
 * wired level from the enables. the software port is synchronous to MCLK.
 */
// Decided for this implementation: strobed register access and the address map.
// Contract
// [RQ1] slave returns one 16-bit word on reads, selected by address 17:01
// [RQ2] destructive slave restores on read_word, sets pause on read_pause
// [RQ3] paused destructive slave skips read and writes at once
// [RQ4] read_pause is followed directly by a write to same place
// [RQ5] non-destructive slave treats read_pause as read_word
// [RQ6] master takes whole words and picks the byte itself
// [RQ7] write_byte drives the selected half; slave updates only it
// [RQ8] master sets type, address, data before raising master_sync
// [RQ9] matching slave captures write data at master_sync, raises slave_sync
// [RQ10] master drops all on slave_sync, waits for its negation
// [RQ11] slave holds slave_sync until master_sync drops
// [RQ12] read slave drives word then raises slave_sync
// [RQ13] master latches read data on slave_sync, withdraws, waits negation
// [RQ14] priority in status bits 7:5 masks requests at that level and below
// [RQ15] dma grant between bus cycles; levels between instructions, high first
// [RQ16] after internal trap, withhold level grants one instruction
// [RQ17] devices pass grant down chain unless requesting on that level
// [RQ18] ranking dma, then levels 7..4 interleaved with processor priority
// [RQ19] selected device waits bus_busy low, then asserts it
// [RQ20] passive release by dropping bus_busy returns control
// [RQ21] vector_interrupt hands vector; processor pushes and loads two words
// [RQ22] dma master never issues vector_interrupt
// [RQ23] type codes 00 read_word 01 read_pause 10 write_word 11 write_byte
// [RQ24] byte_select 0 low byte 7:0, 1 high byte 15:8
// [RQ25] force address 17:16 to ones when 15:13 all ones
// [RQ26] granted requester asserts select_ack, masters after current finishes
// [RQ27] non-matching slave leaves slave_sync and data undriven
`timescale 1ns/1ns
module ibus_host
   import ibus_host_pkg::*;
#(
   parameter int SP_RESET = 16'h0200
)(
   // clock, reset, enable
   input  wire logic              MCLK,
   input  wire logic              RST_B,
   input  wire logic              CE,
   // software command port
   input  wire logic [15:0]       CMD_ADDR,
   input  wire logic [1:0]        CMD_TYPE,
   input  wire logic [15:0]       CMD_WDATA,
   input  wire logic              CMD_GO,
   input  wire logic              INSN_END,
   input  wire logic              TRAP_SEEN,
   input  wire logic [15:0]       PSW_IN,
   input  wire logic              PSW_WR,
   output logic                   CMD_BUSY,
   output logic                   CMD_DONE,
   output logic [15:0]            CMD_RDATA,
   output logic [15:0]            PSW_OUT,
   output logic [15:0]            PC_OUT,
   output logic                   VEC_TAKEN,
   // bus transfer pins
   output logic [17:0]            ADDR_O,
   output logic                   ADDR_OE,
   output logic [1:0]             XTYPE_O,
   output logic [15:0]            DATA_O,
   output logic                   DATA_OE,
   input  wire logic [15:0]       DATA_I,
   output logic                   MASTER_SYNC_O,
   input  wire logic              SLAVE_SYNC_I,
   // arbitration pins
   input  wire logic              DMA_REQUEST_I,
   output logic                   DMA_GRANT_O,
   input  wire logic [LVL_N-1:0]  LEVEL_REQUEST_I,
   output logic [LVL_N-1:0]       LEVEL_GRANT_O,
   input  wire logic              SELECT_ACK_I,
   input  wire logic              BUS_BUSY_I,
   output logic                   BUS_BUSY_O,
   input  wire logic              VECTOR_INTERRUPT_I,
   input  wire logic [15:0]       VEC_DATA_I
);
   // the stack pointer must stay an even 16-bit word address
   if (SP_RESET % 2 != 0 || SP_RESET > 16'hFFFF) begin : g_bad_sp
      $error("SP_RESET must be an even 16-bit address");
   end

   // two-flop synchronisers for every asynchronous input pin except VEC_DATA_I
   logic [1:0]        ss_ff;      // slave_sync
   logic [1:0]        ack_ff;     // select_ack
   logic [1:0]        bb_ff;      // bus_busy as seen on the wire
   logic [1:0]        vi_ff;      // vector_interrupt
   logic [1:0]        dr_ff;      // dma_request
   logic [LVL_N-1:0]  lr_m_ff;
   logic [LVL_N-1:0]  lr_ff;
   logic [15:0]       di_m_ff;
   logic [15:0]       di_ff;      // read data, settled before slave_sync arrives
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         ss_ff   <= 2'h0;
         ack_ff  <= 2'h0;
         bb_ff   <= 2'h0;
         vi_ff   <= 2'h0;
         dr_ff   <= 2'h0;
         lr_m_ff <= '0;
         lr_ff   <= '0;
         di_m_ff <= 16'h0000;
         di_ff   <= 16'h0000;
      end else if (CE) begin
         ss_ff   <= {ss_ff[0], SLAVE_SYNC_I};
         ack_ff  <= {ack_ff[0], SELECT_ACK_I};
         bb_ff   <= {bb_ff[0], BUS_BUSY_I};
         vi_ff   <= {vi_ff[0], VECTOR_INTERRUPT_I};
         dr_ff   <= {dr_ff[0], DMA_REQUEST_I};
         lr_m_ff <= LEVEL_REQUEST_I;
         lr_ff   <= lr_m_ff;
         di_m_ff <= DATA_I;
         di_ff   <= di_m_ff;
      end
   end
   // synchronised pin levels, the only copies the sequencer reads
   wire ss = ss_ff[1];
   wire ack = ack_ff[1];
   wire bus_busy = bb_ff[1];
   wire vint = vi_ff[1];
   wire dreq = dr_ff[1];

   // sequencer state and bus drive registers
   host_st_e          st_ff;
   logic [1:0]        xt_ff;      // transfer type on the lines
   logic [17:0]       ad_ff;      // extended bus address
   logic [15:0]       wd_ff;      // write word, both lanes
   logic [15:0]       rd_ff;      // last word read
   logic [15:0]       psw_ff;     // status word, priority in 7:5
   logic [15:0]       pc_ff;
   logic [15:0]       sp_ff;      // stack pointer for vector pushes
   logic [15:0]       vec_ff;     // vector address from the device
   logic              aoe_ff;
   logic              doe_ff;
   logic              ms_ff;      // master_sync
   logic              busy_ff;
   logic              done_ff;
   logic              vtk_ff;
   logic              dg_ff;      // dma_grant
   logic              bbo_ff;     // own bus_busy drive
   logic              trap_ff;
   logic              dma_own_ff; // device won the bus by dma_request
   logic [LVL_N-1:0]  lg_ff;
   logic [2:0]        seq_ff;   // vector sequence step: push psw, pc, load pc, psw

   // level arbitration: a level wins when above the processor priority
   logic [LVL_N-1:0] lvl_ok;
   genvar g;
   generate
      for (g = 0; g < LVL_N; g++) begin : g_lvl
         assign lvl_ok[g] = lr_ff[g] &&
            (3'(g + LVL_BASE) > psw_ff[PRI_MSB:PRI_LSB]); // RQ14
      end
   endgenerate

   // pick highest eligible level; dma handled ahead of levels
   logic [LVL_N-1:0] lvl_pick;
   always_comb begin
      lvl_pick = '0;
      for (int i = LVL_N-1; i >= 0; i--) begin
         if (lvl_ok[i] && lvl_pick == '0) lvl_pick[i] = 1'b1; // RQ18
      end
   end

   // extend 16-bit program address to 18 bits
   function automatic logic [17:0] ext_addr(input logic [15:0] a);
      ext_addr = {2'h0, a};
      if (a[BANK_MSB:BANK_LSB] == BANK_ALL1) ext_addr[EXT_TOP:EXT_BOT] = EXT_ONES; // RQ25
   endfunction : ext_addr

   // trap holds off level grants until the next instruction ends
   always_ff @(posedge MCLK) begin
      if (!RST_B) trap_ff <= 1'b0;
      else if (CE) begin
         if (TRAP_SEEN) trap_ff <= 1'b1;                  // RQ16
         else if (INSN_END && st_ff == ST_IDLE) trap_ff <= 1'b0;
      end
   end

   // main sequencer: transfers, arbitration and vector service
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         st_ff      <= ST_IDLE;
         xt_ff      <= XT_RDWORD;
         ad_ff      <= 18'h00000;
         wd_ff      <= 16'h0000;
         rd_ff      <= 16'h0000;
         psw_ff     <= 16'h0000;
         pc_ff      <= 16'h0000;
         sp_ff      <= SP_RESET[15:0];
         vec_ff     <= 16'h0000;
         aoe_ff     <= 1'b0;
         doe_ff     <= 1'b0;
         ms_ff      <= 1'b0;
         busy_ff    <= 1'b0;
         done_ff    <= 1'b0;
         vtk_ff     <= 1'b0;
         dg_ff      <= 1'b0;
         lg_ff      <= '0;
         bbo_ff     <= 1'b0;
         dma_own_ff <= 1'b0;
         seq_ff     <= 3'h0;
      end else if (CE) begin
         done_ff <= 1'b0;
         vtk_ff  <= 1'b0;
         if (PSW_WR) psw_ff <= PSW_IN;
         case (st_ff)
            ST_IDLE: begin
               if (dreq) begin                            // RQ15
                  dg_ff      <= 1'b1;
                  dma_own_ff <= 1'b1;
                  st_ff      <= ST_GRANT;
               end else if (INSN_END && !trap_ff && !TRAP_SEEN && lvl_pick != '0) begin
                  lg_ff      <= lvl_pick;                 // RQ15
                  dma_own_ff <= 1'b0;
                  st_ff      <= ST_GRANT;
               end else if (CMD_GO) begin
                  xt_ff   <= CMD_TYPE;                    // RQ23
                  ad_ff   <= ext_addr(CMD_ADDR);
                  wd_ff   <= CMD_WDATA;                   // RQ7 RQ24 byte lanes set by caller
                  aoe_ff  <= 1'b1;
                  doe_ff  <= CMD_TYPE[1];
                  busy_ff <= 1'b1;
                  bbo_ff  <= 1'b1;
                  st_ff   <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               ms_ff <= 1'b1;                             // RQ8 pins stood one cycle
               st_ff <= ST_SYNC;
            end
            ST_SYNC: if (ss) begin
               if (!xt_ff[1]) rd_ff <= di_ff;             // RQ13 RQ6 whole word
               ms_ff  <= 1'b0;                            // RQ10
               aoe_ff <= 1'b0;
               doe_ff <= 1'b0;
               st_ff  <= ST_WAITN;
            end
            // interlock closes only once slave_sync has fallen again
            ST_WAITN: if (!ss) begin                      // RQ10 RQ13
               if (seq_ff != 3'h0) begin
                  st_ff <= ST_PUSH;
               end else begin
                  busy_ff <= 1'b0;
                  done_ff <= 1'b1;
                  bbo_ff  <= 1'b0;
                  st_ff   <= ST_IDLE;
               end
            end
            // grant stands until the winner answers; a stuck chain waits here
            ST_GRANT: if (ack) begin                      // RQ26 selection done
               dg_ff <= 1'b0;
               lg_ff <= '0;
               st_ff <= ST_OWNED;
            end
            ST_OWNED: begin
               if (vint && bus_busy && !dma_own_ff) begin     // RQ21 RQ22
                  vec_ff <= di_ff;
                  st_ff  <= ST_VEC;
               end else if (!bus_busy && !ack) begin          // RQ20 passive release
                  st_ff <= ST_IDLE;
               end
            end
            // pushing before the device lets go would collide on the lines
            ST_VEC: if (!bus_busy) begin                      // RQ19 wait device release
               bbo_ff  <= 1'b1;
               busy_ff <= 1'b1;
               vtk_ff  <= 1'b1;
               seq_ff  <= 3'h1;
               st_ff   <= ST_PUSH;
            end
            ST_PUSH: begin
               // push status, push pc, then load pc and status from the vector
               aoe_ff <= 1'b1;
               st_ff  <= ST_SETUP;
               case (seq_ff)
                  3'h1: begin
                     sp_ff  <= sp_ff - VEC_STEP;
                     ad_ff  <= ext_addr(sp_ff - VEC_STEP);
                     xt_ff  <= XT_WRWORD;
                     wd_ff  <= psw_ff;
                     doe_ff <= 1'b1;
                     seq_ff <= 3'h2;
                  end
                  3'h2: begin
                     sp_ff  <= sp_ff - VEC_STEP;
                     ad_ff  <= ext_addr(sp_ff - VEC_STEP);
                     xt_ff  <= XT_WRWORD;
                     wd_ff  <= pc_ff;
                     doe_ff <= 1'b1;
                     seq_ff <= 3'h3;
                  end
                  3'h3: begin
                     ad_ff  <= ext_addr(vec_ff);
                     xt_ff  <= XT_RDWORD;
                     doe_ff <= 1'b0;
                     seq_ff <= 3'h4;
                  end
                  3'h4: begin
                     pc_ff  <= rd_ff;
                     ad_ff  <= ext_addr(vec_ff + VEC_STEP);
                     xt_ff  <= XT_RDWORD;
                     doe_ff <= 1'b0;
                     seq_ff <= 3'h5;
                  end
                  default: begin
                     psw_ff  <= rd_ff;
                     seq_ff  <= 3'h0;
                     aoe_ff  <= 1'b0;
                     busy_ff <= 1'b0;
                     bbo_ff  <= 1'b0;
                     done_ff <= 1'b1;
                     st_ff   <= ST_IDLE;
                  end
               endcase
            end
            default: st_ff <= ST_IDLE;
         endcase
      end
   end

   // outputs straight from flops
   assign CMD_BUSY      = busy_ff;
   assign CMD_DONE      = done_ff;
   assign CMD_RDATA     = rd_ff;
   assign PSW_OUT       = psw_ff;
   assign PC_OUT        = pc_ff;
   assign VEC_TAKEN     = vtk_ff;
   assign ADDR_O        = ad_ff;
   assign ADDR_OE       = aoe_ff;
   assign XTYPE_O       = xt_ff;
   assign DATA_O        = wd_ff;
   assign DATA_OE       = doe_ff;
   assign MASTER_SYNC_O = ms_ff;
   assign DMA_GRANT_O   = dg_ff;
   assign LEVEL_GRANT_O = lg_ff;
   assign BUS_BUSY_O    = bbo_ff;
endmodule : ibus_host

// *** core/ibus_host_pkg.sv ***
/*
 * constants for the bus host: transfer type codes, byte lane layout,
 * priority field, grant levels and host state encodings.
 * assumes a single-clock synchronous design around an async bus.
 */
package ibus_host_pkg;
   localparam int          DATA_W     = 16;
   localparam int          ADDR_W     = 18;
   localparam int          LVL_N      = 4;    // level_request 7..4
   localparam int          LVL_BASE   = 4;
   localparam logic [1:0]  XT_RDWORD  = 2'h0;
   localparam logic [1:0]  XT_RDPAUSE = 2'h1;
   localparam logic [1:0]  XT_WRWORD  = 2'h2;
   localparam logic [1:0]  XT_WRBYTE  = 2'h3;
   localparam int          LO_MSB     = 7;
   localparam int          HI_LSB     = 8;
   localparam int          PRI_MSB    = 7;    // status word priority field 7:5
   localparam int          PRI_LSB    = 5;
   localparam int          EXT_TOP    = 17;
   localparam int          EXT_BOT    = 16;
   localparam int          BANK_MSB   = 15;
   localparam int          BANK_LSB   = 13;
   localparam logic [2:0]  BANK_ALL1  = 3'h7;
   localparam logic [1:0]  EXT_ONES   = 2'h3;
   localparam logic [15:0] VEC_STEP   = 16'h0002;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'h0,
      ST_SETUP = 4'h1,
      ST_SYNC  = 4'h2,
      ST_WAITN = 4'h3,
      ST_GRANT = 4'h4,
      ST_OWNED = 4'h5,
      ST_VEC   = 4'h6,
      ST_PUSH  = 4'h7
   } host_st_e;
endpackage : ibus_host_pkg
